// >>> logic/operating_mode_controller.sv
/*
 * Operating mode controller: normal, slow, green and power down modes, clock
 * gating, CPU clock selection, wake-up from port level changes or timer overflow.
 * Assumes HOSC_TICK and LOSC_TICK are one-cycle enables on CLOCK standing for the
 * high-speed and low-speed oscillator edges, and that CLOCK itself never stops.
 */
// Function
// - four modes: normal, slow, power down, green.
// - reset release always starts in normal mode.
// - normal mode: cpu on high-speed clock, both oscillators run.
// - slow_clock_select 0 picks high-speed clock, 1 picks low-speed rc.
// - slow mode instruction rate is low-speed rc divided by four.
// - entering slow mode leaves high-speed oscillator running; software stops it.
// - slow and green follow high_osc_stop; low rc runs except power down and warm-up.
// - writing sleep_request 1 enters power down.
// - hardware clears sleep_request on power down wake.
// - power down: oscillators stop, cpu halts, timers idle, no interrupts.
// - power down wake always resumes in normal mode.
// - power down wakes on port a change, enabled port b change, reset.
// - stopping high-speed clock in normal mode acts as power down.
// - writing idle_request 1 enters green mode.
// - hardware clears idle_request on green wake.
// - green: cpu halts, system clock runs, interval timer keeps counting.
// - green wakes on port change, interval_timer overflow or reset.
// - green wake returns to the mode active at entry.
// - green keeps pwm_timer running but its overflow never wakes.
// - mode field bits 4:3: 00 normal, 01 power down, 10 green.
// - high_osc_stop bit 1, slow_clock_select bit 2, read/write, reset 0.
// - power down wake waits 2048 crystal or 32 rc clocks; green none.
module operating_mode_controller #(
    parameter int PORT_A_W = 8,
    parameter int PORT_B_W = 4,
    parameter int WARMUP_CRYSTAL = opmode_pkg::WARMUP_CRYSTAL_CLOCKS,
    parameter int WARMUP_RC = opmode_pkg::WARMUP_RC_CLOCKS
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic [opmode_pkg::ADDR_W-1:0] ADDRESS,
    input wire logic [opmode_pkg::DATA_W-1:0] WRITE_DATA,
    input wire logic WRITE_STROBE,
    input wire logic READ_STROBE,
    output logic [opmode_pkg::DATA_W-1:0] READ_DATA,
    input wire logic [PORT_A_W-1:0] WAKE_PORT_A,
    input wire logic [PORT_B_W-1:0] WAKE_PORT_B,
    input wire logic HOSC_IS_CRYSTAL,
    input wire logic HOSC_TICK,
    input wire logic LOSC_TICK,
    input wire logic INTERVAL_TIMER_ENABLE,
    input wire logic PWM_TIMER_ENABLE,
    input wire logic INTERVAL_TIMER_OVERFLOW,
    output opmode_pkg::clock_ctrl_t CLOCK_CONTROL,
    output opmode_pkg::op_state_t MODE_STATE,
    output opmode_pkg::osc_mode_t OSC_MODE
);
    import opmode_pkg::*;

    // pins and the crystal option strap come from outside the clock domain
    logic [PORT_A_W-1:0] port_a_meta;
    logic [PORT_A_W-1:0] port_a_sync;
    logic [PORT_B_W-1:0] port_b_meta;
    logic [PORT_B_W-1:0] port_b_sync;
    logic crystal_meta;
    logic crystal_sync;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            port_a_meta <= '0;
            port_a_sync <= '0;
            port_b_meta <= '0;
            port_b_sync <= '0;
            crystal_meta <= 1'b0;
            crystal_sync <= 1'b0;
        end else begin
            port_a_meta <= WAKE_PORT_A;
            port_a_sync <= port_a_meta;
            port_b_meta <= WAKE_PORT_B;
            port_b_sync <= port_b_meta;
            crystal_meta <= HOSC_IS_CRYSTAL;
            crystal_sync <= crystal_meta;
        end
    end

    op_state_t state;
    op_state_t next_state;
    osc_mode_t osc_mode;
    osc_mode_t next_osc_mode;
    logic [PORT_B_W-1:0] port1_wake_enable;
    logic [PORT_B_W-1:0] next_port1_wake_enable;
    logic [PORT_A_W-1:0] port_a_ref;
    logic [PORT_A_W-1:0] next_port_a_ref;
    logic [PORT_B_W-1:0] port_b_ref;
    logic [PORT_B_W-1:0] next_port_b_ref;
    logic green_from_slow;
    logic next_green_from_slow;
    logic [WARMUP_CNT_W-1:0] warm_count;
    logic [WARMUP_CNT_W-1:0] next_warm_count;
    logic [1:0] slow_div;
    logic [1:0] next_slow_div;
    logic [DATA_W-1:0] next_read_data;
    clock_ctrl_t next_ctrl;

    logic wr_osc;
    logic port_change;
    logic clock_lost;
    logic warm_done;
    logic slow_tick;
    logic [WARMUP_CNT_W-1:0] warm_last;
    logic [1:0] mode_field;

    assign wr_osc = WRITE_STROBE && (ADDRESS == OSC_MODE_ADDR);
    assign mode_field = WRITE_DATA[IDLE_REQUEST_BIT:SLEEP_REQUEST_BIT];
    // compared against entry levels, so a change that returns before the
    // controller looks still shows only if it stands for one clock
    assign port_change = (port_a_sync != port_a_ref) ||
        (((port_b_sync ^ port_b_ref) & port1_wake_enable) != '0);
    assign clock_lost = osc_mode.high_osc_stop && !osc_mode.slow_clock_select;
    assign warm_last = crystal_sync ? WARMUP_CNT_W'(WARMUP_CRYSTAL - 1) : WARMUP_CNT_W'(WARMUP_RC - 1);
    assign warm_done = HOSC_TICK && (warm_count == warm_last);
    assign slow_tick = LOSC_TICK && (slow_div == 2'(SLOW_DIVIDE - 1));

    // mode register, state machine and wake capture
    always_comb begin
        next_state = state;
        next_osc_mode = osc_mode;
        next_port1_wake_enable = port1_wake_enable;
        next_port_a_ref = port_a_ref;
        next_port_b_ref = port_b_ref;
        next_green_from_slow = green_from_slow;
        next_warm_count = warm_count;
        next_slow_div = slow_div;
        if (LOSC_TICK && state == ST_SLOW) begin
            next_slow_div = slow_div + 2'h1;
        end
        case (state)
            ST_NORMAL,
            ST_SLOW: begin
                next_state = osc_mode.slow_clock_select ? ST_SLOW : ST_NORMAL;
                if (osc_mode.sleep_request || clock_lost) begin
                    next_state = ST_POWER_DOWN;
                    next_port_a_ref = port_a_sync;
                    next_port_b_ref = port_b_sync;
                end else if (osc_mode.idle_request) begin
                    next_state = ST_GREEN;
                    next_green_from_slow = osc_mode.slow_clock_select;
                    next_port_a_ref = port_a_sync;
                    next_port_b_ref = port_b_sync;
                end
            end
            ST_GREEN: begin
                if (port_change || (INTERVAL_TIMER_OVERFLOW && INTERVAL_TIMER_ENABLE)) begin
                    next_state = green_from_slow ? ST_SLOW : ST_NORMAL;
                    next_osc_mode.idle_request = 1'b0;
                end
            end
            ST_POWER_DOWN: begin
                next_warm_count = '0;
                if (port_change) begin
                    next_state = ST_WARMUP;
                end
            end
            ST_WARMUP: begin
                if (HOSC_TICK) begin
                    next_warm_count = warm_count + WARMUP_CNT_W'(1);
                end
                if (warm_done) begin
                    next_state = ST_NORMAL;
                    next_osc_mode.sleep_request = 1'b0;
                    // normal mode needs its clock back
                    next_osc_mode.high_osc_stop = 1'b0;
                    next_osc_mode.slow_clock_select = 1'b0;
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
        // software write lands after the hardware clear, so its set wins
        if (wr_osc) begin
            next_osc_mode.high_osc_stop = WRITE_DATA[HIGH_OSC_STOP_BIT];
            next_osc_mode.slow_clock_select = WRITE_DATA[SLOW_CLOCK_SELECT_BIT];
            // the reserved code requests nothing
            next_osc_mode.sleep_request = (mode_field == CPU_MODE_SLEEP);
            next_osc_mode.idle_request = (mode_field == CPU_MODE_IDLE);
        end
        if (WRITE_STROBE && ADDRESS == PORT1_WAKE_ADDR) begin
            next_port1_wake_enable = WRITE_DATA[PORT_B_W-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state <= ST_NORMAL;
            osc_mode <= OSC_MODE_RESET;
            port1_wake_enable <= PORT1_WAKE_RESET;
            port_a_ref <= '0;
            port_b_ref <= '0;
            green_from_slow <= 1'b0;
            warm_count <= '0;
            slow_div <= 2'h0;
        end else begin
            state <= next_state;
            osc_mode <= next_osc_mode;
            port1_wake_enable <= next_port1_wake_enable;
            port_a_ref <= next_port_a_ref;
            port_b_ref <= next_port_b_ref;
            green_from_slow <= next_green_from_slow;
            warm_count <= next_warm_count;
            slow_div <= next_slow_div;
        end
    end

    // clock and execution controls, registered from the next state
    always_comb begin
        next_ctrl = '0;
        next_read_data = '0;
        case (next_state)
            ST_NORMAL: begin
                next_ctrl.high_osc_run = 1'b1;
                next_ctrl.low_osc_run = 1'b1;
                next_ctrl.cpu_run = 1'b1;
                next_ctrl.cpu_clock_en = HOSC_TICK;
            end
            ST_SLOW: begin
                next_ctrl.high_osc_run = !next_osc_mode.high_osc_stop;
                next_ctrl.low_osc_run = 1'b1;
                next_ctrl.cpu_run = 1'b1;
                next_ctrl.cpu_clock_en = slow_tick;
            end
            ST_GREEN: begin
                next_ctrl.high_osc_run = !next_osc_mode.high_osc_stop;
                next_ctrl.low_osc_run = 1'b1;
            end
            ST_WARMUP: begin
                next_ctrl.high_osc_run = 1'b1;
            end
            default: begin
                next_ctrl = '0;
            end
        endcase
        next_ctrl.interval_timer_run = INTERVAL_TIMER_ENABLE &&
            (next_state inside {ST_NORMAL, ST_SLOW, ST_GREEN});
        next_ctrl.pwm_timer_run = PWM_TIMER_ENABLE &&
            (next_state inside {ST_NORMAL, ST_SLOW, ST_GREEN});
        next_ctrl.interrupt_accept = next_state inside {ST_NORMAL, ST_SLOW, ST_GREEN};
        if (READ_STROBE && ADDRESS == OSC_MODE_ADDR) begin
            next_read_data[HIGH_OSC_STOP_BIT] = osc_mode.high_osc_stop;
            next_read_data[SLOW_CLOCK_SELECT_BIT] = osc_mode.slow_clock_select;
            next_read_data[SLEEP_REQUEST_BIT] = osc_mode.sleep_request;
            next_read_data[IDLE_REQUEST_BIT] = osc_mode.idle_request;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            CLOCK_CONTROL <= '0;
            READ_DATA <= '0;
        end else begin
            CLOCK_CONTROL <= next_ctrl;
            READ_DATA <= next_read_data;
        end
    end

    assign MODE_STATE = state;
    assign OSC_MODE = osc_mode;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    a_reset_normal: assert property ($rose(RESETN) |-> state == ST_NORMAL)
        else $error("reset did not leave normal mode");
    a_sleep_entry: assert property ((state inside {ST_NORMAL, ST_SLOW}) && osc_mode.sleep_request
        |=> state == ST_POWER_DOWN ##1 CLOCK_CONTROL == '0)
        else $error("sleep request did not reach power down");
    a_powerdown_quiet: assert property (state == ST_POWER_DOWN && $past(state) == ST_POWER_DOWN
        |-> !CLOCK_CONTROL.high_osc_run && !CLOCK_CONTROL.low_osc_run && !CLOCK_CONTROL.interrupt_accept)
        else $error("activity during power down");
    a_warm_to_normal: assert property (state == ST_WARMUP && warm_done
        |=> state == ST_NORMAL && !osc_mode.sleep_request)
        else $error("warm-up did not end in normal mode with sleep cleared");
    a_warm_length: assert property ($rose(state == ST_WARMUP) && crystal_sync
        |-> (state == ST_WARMUP) [*8])
        else $error("crystal warm-up ended too soon");
    a_green_return: assert property (state == ST_GREEN && next_state != ST_GREEN
        |=> state == (green_from_slow ? ST_SLOW : ST_NORMAL) && !osc_mode.idle_request)
        else $error("green wake went to the wrong mode");
    a_green_pwm_nowake: assert property (state == ST_GREEN && !port_change &&
        !(INTERVAL_TIMER_OVERFLOW && INTERVAL_TIMER_ENABLE) |=> state == ST_GREEN)
        else $error("green mode left without a wake source");
    a_slow_divide: assert property (state == ST_SLOW && $past(state) == ST_SLOW && CLOCK_CONTROL.cpu_clock_en
        |=> !CLOCK_CONTROL.cpu_clock_en [*3])
        else $error("slow cpu clock faster than quarter rate");
    a_clock_lost: assert property (state == ST_NORMAL && clock_lost && !osc_mode.sleep_request
        |=> state == ST_POWER_DOWN)
        else $error("lost clock did not stop the device");
    a_green_timer: assert property (state == ST_GREEN && $past(state) == ST_GREEN && INTERVAL_TIMER_ENABLE
        && $past(INTERVAL_TIMER_ENABLE) |-> CLOCK_CONTROL.interval_timer_run && !CLOCK_CONTROL.cpu_run)
        else $error("green mode timer or cpu wrong");

    // clock controls are registered from the next state, so they lag reset release by one edge
    a_mode_onehot: assert property ($onehot(state))
        else $error("mode state not one-hot");
    a_normal_clocks: assert property ($past(RESETN) && state == ST_NORMAL
        |-> CLOCK_CONTROL.high_osc_run && CLOCK_CONTROL.low_osc_run && CLOCK_CONTROL.cpu_run)
        else $error("normal mode clocks wrong");
    a_slow_clocks: assert property ($past(RESETN) && state == ST_SLOW
        |-> CLOCK_CONTROL.low_osc_run && CLOCK_CONTROL.cpu_run
        && CLOCK_CONTROL.high_osc_run == !osc_mode.high_osc_stop)
        else $error("slow mode clocks wrong");
    a_green_halt: assert property ($past(RESETN) && state == ST_GREEN
        |-> !CLOCK_CONTROL.cpu_run && CLOCK_CONTROL.low_osc_run
        && CLOCK_CONTROL.high_osc_run == !osc_mode.high_osc_stop)
        else $error("green mode clocks wrong");
    a_powerdown_timers: assert property ($past(RESETN) && state == ST_POWER_DOWN
        |-> !CLOCK_CONTROL.interval_timer_run && !CLOCK_CONTROL.pwm_timer_run && !CLOCK_CONTROL.cpu_run)
        else $error("timers or cpu active in power down");
    a_interrupt_gate: assert property ($past(RESETN)
        |-> CLOCK_CONTROL.interrupt_accept == (state inside {ST_NORMAL, ST_SLOW, ST_GREEN}))
        else $error("interrupt acceptance wrong for mode");
    a_slow_select: assert property ((state inside {ST_NORMAL, ST_SLOW}) && !osc_mode.sleep_request
        && !osc_mode.idle_request && !clock_lost
        |=> state == ($past(osc_mode.slow_clock_select) ? ST_SLOW : ST_NORMAL))
        else $error("clock select did not pick the mode");
    a_idle_entry: assert property ((state inside {ST_NORMAL, ST_SLOW}) && osc_mode.idle_request
        && !osc_mode.sleep_request && !clock_lost |=> state == ST_GREEN)
        else $error("idle request did not reach green");
    a_green_latch: assert property ((state inside {ST_NORMAL, ST_SLOW}) && osc_mode.idle_request
        && !osc_mode.sleep_request && !clock_lost
        |=> green_from_slow == $past(osc_mode.slow_clock_select))
        else $error("green entry did not latch the clock selection");
    a_port_wake: assert property (state == ST_POWER_DOWN && port_change |=> state == ST_WARMUP)
        else $error("port change did not wake power down");
    a_powerdown_hold: assert property (state == ST_POWER_DOWN && !port_change
        |=> state == ST_POWER_DOWN)
        else $error("power down left without a port change");
    a_warm_clocks: assert property ($past(RESETN) && state == ST_WARMUP
        |-> CLOCK_CONTROL.high_osc_run && !CLOCK_CONTROL.cpu_run)
        else $error("warm-up clocks wrong");
    a_warm_rc_length: assert property ($rose(state == ST_WARMUP) && !crystal_sync
        |-> (state == ST_WARMUP) [*4])
        else $error("rc warm-up ended too soon");
    a_read_idle: assert property (!$past(READ_STROBE) |-> READ_DATA == '0)
        else $error("read data stands without a read");
    a_read_mode: assert property ($past(RESETN) && $past(READ_STROBE) && $past(ADDRESS) == OSC_MODE_ADDR
        |-> READ_DATA == {3'h0, $past(osc_mode), 1'b0})
        else $error("mode register read wrong");
endmodule : operating_mode_controller

// >>> pkg/opmode_pkg.sv
/*
 * Shared constants and types of the operating mode controller: register map,
 * field positions, reset values, warm-up counts, mode state codes and carriers.
 * Assumes an 8-bit register port and one 10 MHz system clock.
 */
package opmode_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OSC_MODE_ADDR = 8'hca;
    localparam logic [7:0] PORT1_WAKE_ADDR = 8'hc0;
    localparam int HIGH_OSC_STOP_BIT = 1;
    localparam int SLOW_CLOCK_SELECT_BIT = 2;
    localparam int SLEEP_REQUEST_BIT = 3;
    localparam int IDLE_REQUEST_BIT = 4;
    localparam logic [1:0] CPU_MODE_NORMAL = 2'h0;
    localparam logic [1:0] CPU_MODE_SLEEP = 2'h1;
    localparam logic [1:0] CPU_MODE_IDLE = 2'h2;
    localparam logic [3:0] OSC_MODE_RESET = 4'h0;
    localparam logic [3:0] PORT1_WAKE_RESET = 4'h0;
    localparam int WARMUP_CRYSTAL_CLOCKS = 2048;
    localparam int WARMUP_RC_CLOCKS = 32;
    localparam int SLOW_DIVIDE = 4;
    localparam int WARMUP_CNT_W = 12;

    typedef struct packed {
        logic idle_request;
        logic sleep_request;
        logic slow_clock_select;
        logic high_osc_stop;
    } osc_mode_t;

    typedef struct packed {
        logic high_osc_run;
        logic low_osc_run;
        logic cpu_run;
        logic cpu_clock_en;
        logic interval_timer_run;
        logic pwm_timer_run;
        logic interrupt_accept;
    } clock_ctrl_t;

    typedef enum logic [4:0] {
        ST_NORMAL = 5'h01,
        ST_SLOW = 5'h02,
        ST_GREEN = 5'h04,
        ST_POWER_DOWN = 5'h08,
        ST_WARMUP = 5'h10
    } op_state_t;
endpackage : opmode_pkg

// >>> verification/testbench.sv
/*
 * Self-checking bench of the operating mode controller: register access, slow, green and power down modes,
 * wake-up sources and warm-up counts. Assumes the opmode package and that the design checks itself inline.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import opmode_pkg::*;
    // short warm-up counts keep the run brief; expectations use the same values
    localparam int WX = 8;
    localparam int WR = 4;
    logic CLOCK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] ADDRESS = 8'h00;
    logic [7:0] WRITE_DATA = 8'h00;
    logic WRITE_STROBE = 1'b0;
    logic READ_STROBE = 1'b0;
    logic [7:0] READ_DATA;
    logic [7:0] WAKE_PORT_A = 8'h00;
    logic [3:0] WAKE_PORT_B = 4'h0;
    logic HOSC_IS_CRYSTAL = 1'b0;
    logic HOSC_TICK = 1'b0;
    logic LOSC_TICK = 1'b0;
    logic INTERVAL_TIMER_ENABLE = 1'b0;
    logic PWM_TIMER_ENABLE = 1'b0;
    logic INTERVAL_TIMER_OVERFLOW = 1'b0;
    clock_ctrl_t CLOCK_CONTROL;
    op_state_t MODE_STATE;
    osc_mode_t OSC_MODE;
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] cnt;
    logic [7:0] addr;

    operating_mode_controller #(.WARMUP_CRYSTAL(WX), .WARMUP_RC(WR)) dut (.CLOCK(CLOCK), .RESETN(RESETN),
        .ADDRESS(ADDRESS), .WRITE_DATA(WRITE_DATA), .WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE),
        .READ_DATA(READ_DATA), .WAKE_PORT_A(WAKE_PORT_A), .WAKE_PORT_B(WAKE_PORT_B),
        .HOSC_IS_CRYSTAL(HOSC_IS_CRYSTAL), .HOSC_TICK(HOSC_TICK), .LOSC_TICK(LOSC_TICK),
        .INTERVAL_TIMER_ENABLE(INTERVAL_TIMER_ENABLE), .PWM_TIMER_ENABLE(PWM_TIMER_ENABLE),
        .INTERVAL_TIMER_OVERFLOW(INTERVAL_TIMER_OVERFLOW), .CLOCK_CONTROL(CLOCK_CONTROL),
        .MODE_STATE(MODE_STATE), .OSC_MODE(OSC_MODE));

    always #50 CLOCK = ~CLOCK;

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task cycles(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask : cycles

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        WRITE_STROBE <= 1'b1;
        ADDRESS <= a;
        WRITE_DATA <= d;
        @(posedge CLOCK);
        WRITE_STROBE <= 1'b0;
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLOCK);
        READ_STROBE <= 1'b1;
        ADDRESS <= a;
        @(posedge CLOCK);
        READ_STROBE <= 1'b0;
        #1;
        check(READ_DATA, exp);
    endtask : rd_chk

    // bounded wait for a state; running out of the bound ends the run
    task wait_mode(input op_state_t s, input int n);
        for (int i = 0; i < n; i++) begin
            cycles(1);
            if (MODE_STATE === s) begin
                check_count++;
                return;
            end
        end
        n_mismatch++;
        $display("[ERR] %0t state %h not reached", $time, s);
        print_verdict();
    endtask : wait_mode

    task tick_hosc(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            HOSC_TICK <= 1'b1;
            @(posedge CLOCK);
            HOSC_TICK <= 1'b0;
        end
        #1;
    endtask : tick_hosc

    task pulse_overflow;
        @(posedge CLOCK);
        INTERVAL_TIMER_OVERFLOW <= 1'b1;
        @(posedge CLOCK);
        INTERVAL_TIMER_OVERFLOW <= 1'b0;
    endtask : pulse_overflow

    function automatic logic [7:0] run_bits(input clock_ctrl_t c);
        return {5'h0, c.high_osc_run, c.low_osc_run, c.cpu_run};
    endfunction : run_bits

    initial begin
        cnt = 8'($urandom(32'h9d84ba6d));
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'b1;
        cycles(3);
        check({3'h0, MODE_STATE}, {3'h0, ST_NORMAL});
        check(run_bits(CLOCK_CONTROL), 8'h07);
        rd_chk(OSC_MODE_ADDR, 8'h00);
        // unmapped places take no write and read as zero
        repeat (4) begin
            addr = 8'($urandom);
            if (addr == OSC_MODE_ADDR || addr == PORT1_WAKE_ADDR) begin
                addr = addr ^ 8'h01;
            end
            wr(addr, 8'($urandom));
            rd_chk(addr, 8'h00);
        end
        rd_chk(PORT1_WAKE_ADDR, 8'h00);
        rd_chk(OSC_MODE_ADDR, 8'h00);
        // reserved mode code is dropped, slow select kept
        wr(OSC_MODE_ADDR, 8'h1c);
        rd_chk(OSC_MODE_ADDR, 8'h04);
        check({4'h0, OSC_MODE}, 8'h02);
        wait_mode(ST_SLOW, 4);
        check({7'h0, CLOCK_CONTROL.high_osc_run}, 8'h01);
        // 40 back-to-back ticks give exactly 10 cpu pulses whatever the divider phase
        cnt = 8'h00;
        for (int i = 0; i < 46; i++) begin
            @(posedge CLOCK);
            LOSC_TICK <= (i < 40);
            #1;
            cnt = cnt + {7'h0, CLOCK_CONTROL.cpu_clock_en};
        end
        check(cnt, 8'd10);
        wr(OSC_MODE_ADDR, 8'h06);
        cycles(3);
        check(run_bits(CLOCK_CONTROL), 8'h03);
        check({3'h0, MODE_STATE}, {3'h0, ST_SLOW});
        // green from slow with the high oscillator stopped
        PWM_TIMER_ENABLE <= 1'b1;
        wr(OSC_MODE_ADDR, 8'h16);
        wait_mode(ST_GREEN, 4);
        check(run_bits(CLOCK_CONTROL), 8'h02);
        check({7'h0, CLOCK_CONTROL.pwm_timer_run}, 8'h01);
        pulse_overflow();
        cycles(3);
        check({3'h0, MODE_STATE}, {3'h0, ST_GREEN});
        INTERVAL_TIMER_ENABLE <= 1'b1;
        cycles(2);
        check({7'h0, CLOCK_CONTROL.interval_timer_run}, 8'h01);
        pulse_overflow();
        wait_mode(ST_SLOW, 3);
        rd_chk(OSC_MODE_ADDR, 8'h06);
        // green from normal, woken by a port a edge
        wr(OSC_MODE_ADDR, 8'h00);
        wait_mode(ST_NORMAL, 4);
        wr(OSC_MODE_ADDR, 8'h10);
        wait_mode(ST_GREEN, 4);
        cycles(3);
        WAKE_PORT_A <= WAKE_PORT_A ^ (8'h01 << ($urandom % 8));
        wait_mode(ST_NORMAL, 6);
        rd_chk(OSC_MODE_ADDR, 8'h00);
        // power down from slow with a crystal; only enabled port b bits wake
        HOSC_IS_CRYSTAL <= 1'b1;
        wr(PORT1_WAKE_ADDR, 8'h01);
        wr(OSC_MODE_ADDR, 8'h04);
        wait_mode(ST_SLOW, 4);
        wr(OSC_MODE_ADDR, 8'h0c);
        wait_mode(ST_POWER_DOWN, 4);
        check({1'h0, CLOCK_CONTROL}, 8'h00);
        WAKE_PORT_B <= WAKE_PORT_B ^ 4'h2;
        pulse_overflow();
        cycles(6);
        check({3'h0, MODE_STATE}, {3'h0, ST_POWER_DOWN});
        WAKE_PORT_B <= WAKE_PORT_B ^ 4'h1;
        wait_mode(ST_WARMUP, 6);
        tick_hosc(WX - 1);
        check({3'h0, MODE_STATE}, {3'h0, ST_WARMUP});
        tick_hosc(1);
        wait_mode(ST_NORMAL, 3);
        rd_chk(OSC_MODE_ADDR, 8'h00);
        // stopping the high clock in normal mode loses the cpu clock
        HOSC_IS_CRYSTAL <= 1'b0;
        cycles(4);
        wr(OSC_MODE_ADDR, 8'h02);
        wait_mode(ST_POWER_DOWN, 4);
        check({7'h0, CLOCK_CONTROL.interval_timer_run}, 8'h00);
        WAKE_PORT_A <= WAKE_PORT_A ^ (8'h01 << ($urandom % 8));
        wait_mode(ST_WARMUP, 6);
        tick_hosc(WR - 1);
        check({3'h0, MODE_STATE}, {3'h0, ST_WARMUP});
        tick_hosc(1);
        wait_mode(ST_NORMAL, 3);
        // reset released in green from slow must still start in normal mode
        wr(OSC_MODE_ADDR, 8'h16);
        wait_mode(ST_GREEN, 4);
        @(posedge CLOCK);
        RESETN <= 1'b0;
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'b1;
        cycles(3);
        check({3'h0, MODE_STATE}, {3'h0, ST_NORMAL});
        check({4'h0, OSC_MODE}, 8'h00);
        check(run_bits(CLOCK_CONTROL), 8'h07);
        print_verdict();
    end
endmodule : testbench
